/* logic/dsfe_top.sv */
// error insertion, far-end block error coding, forced resync and real-time alarm status
// for one DS3/E3 framer channel. assumes the formatter and framer sit outside on the line
// clocks: their markers arrive as pins and are synchronised here; line clocks are sampled.
`timescale 1ns/100ps
`include "dsfe_regs.svh"

module dsfe_top (
  input  wire logic        core_clk,          // 25 MHz core clock
  input  wire logic        arst_n,            // async reset, active low
  input  wire logic        clk_en,            // freezes all state while low
  input  wire logic [7:0]  avs_address,       // byte address
  input  wire logic        avs_read,          // read request
  input  wire logic        avs_write,         // write request
  input  wire logic [31:0] avs_writedata,     // write data
  input  wire logic [3:0]  avs_byteenable,    // byte lanes
  output logic      [31:0] avs_readdata,      // read data
  output logic             avs_waitrequest,   // stall
  input  wire logic        tx_line_clk,       // transmit line clock
  input  wire logic        tx_frame_start,    // formatter frame start marker
  input  wire logic        tx_data,           // transmit bit before line coding
  input  wire logic        tx_subst_due,      // a zero substitution would occur this bit
  input  wire logic        manual_insert_strobe, // external manual insert strobe
  input  wire logic        rx_line_clk,       // receive line clock
  input  wire logic        rx_fm_error,       // received F or M bit in error
  input  wire logic        rx_cp_error,       // received CP parity error
  input  wire logic        rx_los,            // framer loss of signal
  input  wire logic        liu_los,           // line unit loss of signal
  input  wire logic        rx_oof,            // out of frame
  input  wire logic        rx_ais,            // alarm indication detected
  input  wire logic        rx_rai,            // remote alarm on X or Sa bits
  input  wire logic        idle_signal_detected, // DS3 idle signal detected
  input  wire logic        rx_sef,            // severely errored frame
  output logic             febe_c_zero,       // drive subframe-4 C bits to zero
  output logic             p_invert,          // invert both P bits this frame
  output logic             cp_invert,         // invert all CP bits this frame
  output logic             fbit_error,        // DS3 F-bit error this frame
  output logic             mbit_error,        // DS3 M-bit error this frame
  output logic             fas_one_bit,       // E3 alignment word with one bit inverted
  output logic             fas_all_bits,      // E3 alignment word fully inverted
  output logic             bpv_now,           // insert a bipolar violation this bit
  output logic             exz_suppress,      // suppress the next substitution
  output logic             rx_resync          // one-cycle resync pulse to receive framer
);

  // ===================================================================
  // synchronisers
  localparam int NSYNC = 15;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] raw_in;

  assign raw_in = {rx_sef, idle_signal_detected, rx_rai, rx_ais, rx_oof, liu_los, rx_los,
                   rx_cp_error, rx_fm_error, rx_line_clk, manual_insert_strobe,
                   tx_subst_due, tx_data, tx_frame_start, tx_line_clk};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (clk_en) begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  logic s_txclk, s_sof, s_data, s_subst, s_strobe, s_rxclk;
  logic s_fmerr, s_cperr, s_los, s_liulos, s_oof, s_ais, s_rai, s_idle, s_sef;
  assign {s_sef, s_idle, s_rai, s_ais, s_oof, s_liulos, s_los, s_cperr, s_fmerr,
          s_rxclk, s_strobe, s_subst, s_data, s_sof, s_txclk} = sync_b;

  // edge detectors read only the second stage
  logic txclk_q, rxclk_q, strobe_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txclk_q  <= 1'b0;
      rxclk_q  <= 1'b0;
      strobe_q <= 1'b0;
    end else if (clk_en) begin
      txclk_q  <= s_txclk;
      rxclk_q  <= s_rxclk;
      strobe_q <= s_strobe;
    end
  end

  logic tx_edge, rx_edge, strobe_rise, frame_edge;
  assign tx_edge     = s_txclk & ~txclk_q;
  assign rx_edge     = s_rxclk & ~rxclk_q;
  assign strobe_rise = s_strobe & ~strobe_q;
  assign frame_edge  = tx_edge & s_sof;

  // ===================================================================
  // registers
  logic [7:0] eic;
  logic [7:0] ctrl2;
  logic [7:0] mode;
  logic [7:0] status;

  logic ds3_mode, cbit_ds3, binary_mode, manual_mode;
  assign ds3_mode    = mode[`DSFE_MD_DS3];
  assign cbit_ds3    = mode[`DSFE_MD_DS3] & mode[`DSFE_MD_CBIT];
  assign binary_mode = mode[`DSFE_MD_BINARY];
  assign manual_mode = eic[`DSFE_EIC_MANUAL];

  logic req, wr_take, rd_take;
  logic [5:0] idx;
  assign req     = avs_read | avs_write;
  assign idx     = avs_address[7:2];
  assign wr_take = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign rd_take = avs_read & avs_waitrequest;

  // one wait cycle: waitrequest drops for exactly one cycle per request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= ~(req & avs_waitrequest);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eic   <= `DSFE_RST_EIC;
      ctrl2 <= `DSFE_RST_CTRL2;
      mode  <= `DSFE_RST_MODE;
    end else if (clk_en && wr_take) begin
      if (idx == `DSFE_IDX_EIC) begin
        eic <= avs_writedata[7:0];
      end else if (idx == `DSFE_IDX_CTRL2) begin
        ctrl2 <= avs_writedata[7:0] & `DSFE_CTRL2_MASK;
      end else if (idx == `DSFE_IDX_MODE) begin
        mode <= avs_writedata[7:0] & `DSFE_MODE_MASK;
      end
    end
  end

  // unmapped reads return zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en && rd_take) begin
      if (idx == `DSFE_IDX_EIC) begin
        avs_readdata <= {24'h00_0000, eic};
      end else if (idx == `DSFE_IDX_CTRL2) begin
        avs_readdata <= {24'h00_0000, ctrl2};
      end else if (idx == `DSFE_IDX_STATUS) begin
        avs_readdata <= {24'h00_0000, status};
      end else if (idx == `DSFE_IDX_MODE) begin
        avs_readdata <= {24'h00_0000, mode};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // ===================================================================
  // real-time status, bits 7:6 read zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= 8'h00;
    end else if (clk_en) begin
      status[0] <= binary_mode ? s_liulos : s_los;
      status[1] <= s_oof;
      status[2] <= s_ais;
      status[3] <= s_rai;
      status[4] <= s_idle;
      status[5] <= s_sef;
      status[7:6] <= 2'b00;
    end
  end

  // ===================================================================
  // insertion triggers
  logic [4:0] eic_prev;
  logic [4:0] trig;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eic_prev <= 5'h00;
    end else if (clk_en) begin
      eic_prev <= eic[4:0];
    end
  end

  // manual mode fires every bit held high on each rising edge of the strobe; normal mode fires on each rising bit
  assign trig = manual_mode ? (strobe_rise ? eic[4:0] : 5'h00)
                            : (eic[4:0] & ~eic_prev);

  // ===================================================================
  // forced resync pulse
  logic resync_prev;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      resync_prev <= 1'b0;
      rx_resync   <= 1'b0;
    end else if (clk_en) begin
      resync_prev <= ctrl2[`DSFE_C2_RESYNC];
      rx_resync   <= ctrl2[`DSFE_C2_RESYNC] & ~resync_prev;
    end
  end

  // ===================================================================
  // far-end block error: collect errors over a frame, code at the next frame start
  logic febe_seen;
  logic febe_frame;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      febe_seen  <= 1'b0;
      febe_frame <= 1'b0;
    end else if (clk_en) begin
      if (frame_edge) begin
        febe_frame <= febe_seen | (rx_edge & (s_fmerr | s_cperr | s_oof));
        febe_seen  <= 1'b0;
      end else if (rx_edge && (s_fmerr || s_cperr || s_oof)) begin
        febe_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      febe_c_zero <= 1'b0;
    end else if (clk_en) begin
      if (!cbit_ds3) begin
        febe_c_zero <= 1'b0;
      end else if (ctrl2[`DSFE_C2_AUTO_DEFEAT]) begin
        febe_c_zero <= ctrl2[`DSFE_C2_FORCED_SET];
      end else begin
        febe_c_zero <= febe_frame;
      end
    end
  end

  // ===================================================================
  // parity errors: pending until the next frame start, then held one frame
  logic pend_p, pend_cp;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_p    <= 1'b0;
      pend_cp   <= 1'b0;
      p_invert  <= 1'b0;
      cp_invert <= 1'b0;
    end else if (clk_en) begin
      if (trig[`DSFE_EIC_PPAR] && ds3_mode) begin
        pend_p <= 1'b1;
      end else if (frame_edge) begin
        pend_p <= 1'b0;
      end
      if (trig[`DSFE_EIC_CPPAR] && cbit_ds3) begin
        pend_cp <= 1'b1;
      end else if (frame_edge) begin
        pend_cp <= 1'b0;
      end
      if (frame_edge) begin
        p_invert  <= pend_p & ds3_mode;
        cp_invert <= pend_cp & cbit_ds3;
      end
    end
  end

  // ===================================================================
  // framing error injector
  dsfe_pkg::dsfe_fstate_e fstate;
  dsfe_pkg::dsfe_ftype_e  ftype;
  logic [2:0] frames_left;

  function automatic logic [2:0] frames_for(input dsfe_pkg::dsfe_ftype_e t, input logic ds3);
    case (t)
      dsfe_pkg::FT_ONE_F:   frames_for = `DSFE_FRAMES_ONE;
      dsfe_pkg::FT_ONE_M:   frames_for = `DSFE_FRAMES_ONE;
      dsfe_pkg::FT_FOUR_F:  frames_for = `DSFE_FRAMES_FOUR;
      default:              frames_for = ds3 ? `DSFE_FRAMES_THREE : `DSFE_FRAMES_FOUR;
    endcase
  endfunction

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fstate      <= dsfe_pkg::FE_IDLE;
      ftype       <= dsfe_pkg::FT_ONE_F;
      frames_left <= 3'd0;
    end else if (clk_en) begin
      case (fstate)
        dsfe_pkg::FE_IDLE: begin
          if (trig[`DSFE_EIC_FRAME]) begin
            fstate <= dsfe_pkg::FE_ARMED;
            ftype  <= dsfe_pkg::dsfe_ftype_e'(eic[`DSFE_EIC_TYPE_LO +: 2]);
          end
        end
        dsfe_pkg::FE_ARMED: begin
          if (frame_edge) begin
            fstate      <= dsfe_pkg::FE_ACTIVE;
            frames_left <= frames_for(ftype, ds3_mode);
          end
        end
        dsfe_pkg::FE_ACTIVE: begin
          if (frame_edge) begin
            if (frames_left == `DSFE_FRAMES_ONE) begin
              fstate      <= trig[`DSFE_EIC_FRAME] ? dsfe_pkg::FE_ARMED : dsfe_pkg::FE_IDLE;
              frames_left <= 3'd0;
            end else begin
              frames_left <= frames_left - 3'd1;
            end
          end
          if (trig[`DSFE_EIC_FRAME]) begin
            ftype <= dsfe_pkg::dsfe_ftype_e'(eic[`DSFE_EIC_TYPE_LO +: 2]);
          end
        end
        default: begin
          fstate <= dsfe_pkg::FE_IDLE;
        end
      endcase
    end
  end

  // a request arriving while active only retypes the current burst; it is kept only if it lands on the burst's last frame start
  logic f_run;
  assign f_run = (fstate == dsfe_pkg::FE_ACTIVE) && !(frame_edge && frames_left == `DSFE_FRAMES_ONE);
  logic f_start;
  assign f_start = (fstate == dsfe_pkg::FE_ARMED) && frame_edge;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fbit_error   <= 1'b0;
      mbit_error   <= 1'b0;
      fas_one_bit  <= 1'b0;
      fas_all_bits <= 1'b0;
    end else if (clk_en) begin
      if (f_start || f_run) begin
        fbit_error   <= ds3_mode & ~ftype[0];
        mbit_error   <= ds3_mode & ftype[0];
        fas_one_bit  <= ~ds3_mode & ~ftype[0];
        fas_all_bits <= ~ds3_mode & ftype[0];
      end else begin
        fbit_error   <= 1'b0;
        mbit_error   <= 1'b0;
        fas_one_bit  <= 1'b0;
        fas_all_bits <= 1'b0;
      end
    end
  end

  // ===================================================================
  // bipolar violation: wait for the third consecutive one
  logic       pend_bpv;
  logic [1:0] ones_run;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ones_run <= 2'd0;
    end else if (clk_en && tx_edge) begin
      if (!s_data) begin
        ones_run <= 2'd0;
      end else if (ones_run != `DSFE_ONES_RUN) begin
        ones_run <= ones_run + 2'd1;
      end else begin
        ones_run <= 2'd1;
      end
    end
  end

  logic bpv_hit;
  assign bpv_hit = tx_edge & s_data & (ones_run == 2'd2) & pend_bpv;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_bpv <= 1'b0;
      bpv_now  <= 1'b0;
    end else if (clk_en) begin
      if (binary_mode) begin
        pend_bpv <= 1'b0;
      end else if (trig[`DSFE_EIC_BPV]) begin
        pend_bpv <= 1'b1;
      end else if (bpv_hit) begin
        pend_bpv <= 1'b0;
      end
      bpv_now <= bpv_hit & ~binary_mode;
    end
  end

  // ===================================================================
  // excess zeros: hold suppression until a substitution is skipped
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      exz_suppress <= 1'b0;
    end else if (clk_en) begin
      if (binary_mode) begin
        exz_suppress <= 1'b0;
      end else if (trig[`DSFE_EIC_EXZ]) begin
        exz_suppress <= 1'b1;
      end else if (tx_edge && s_subst) begin
        exz_suppress <= 1'b0;
      end
    end
  end

endmodule // dsfe_top

/* shared/dsfe_pkg.sv */
// types shared by the error insert block
// assumes nothing of its surroundings
package dsfe_pkg;

  // one-hot states of the framing error injector
  typedef enum logic [2:0] {
    FE_IDLE   = 3'b001,
    FE_ARMED  = 3'b010,
    FE_ACTIVE = 3'b100
  } dsfe_fstate_e;

  // framing error kinds, encoded as the two-bit type field
  typedef enum logic [1:0] {
    FT_ONE_F  = 2'b00,
    FT_ONE_M  = 2'b01,
    FT_FOUR_F = 2'b10,
    FT_THREE_M = 2'b11
  } dsfe_ftype_e;

endpackage

/* shared/dsfe_regs.svh */
// register offsets, field positions, reset values and timing counts of the error insert block
// assumes a 25 MHz core clock and a 32-bit avalon-mm slave, one register per word
`ifndef DSFE_REGS_SVH
`define DSFE_REGS_SVH

// ===================================================================
// register indices, byte address is four times the index
`define DSFE_IDX_CTRL2      6'h11
`define DSFE_IDX_EIC        6'h12
`define DSFE_IDX_STATUS     6'h18
`define DSFE_IDX_MODE       6'h30

// ===================================================================
// field positions
`define DSFE_C2_AUTO_DEFEAT 4
`define DSFE_C2_FORCED_SET  5
`define DSFE_C2_RESYNC      7
`define DSFE_EIC_BPV        0
`define DSFE_EIC_EXZ        1
`define DSFE_EIC_PPAR       2
`define DSFE_EIC_CPPAR      3
`define DSFE_EIC_FRAME      4
`define DSFE_EIC_TYPE_LO    5
`define DSFE_EIC_MANUAL     7
`define DSFE_MD_DS3         0
`define DSFE_MD_CBIT        1
`define DSFE_MD_BINARY      2

// ===================================================================
// reset values and masks
`define DSFE_RST_EIC        8'h00
`define DSFE_RST_CTRL2      8'h00
`define DSFE_RST_MODE       8'h00
`define DSFE_CTRL2_MASK     8'hbf
`define DSFE_MODE_MASK      8'h07

// ===================================================================
// timing counts, in frames and bits
`define DSFE_ONES_RUN       2'd3
`define DSFE_FRAMES_ONE     3'd1
`define DSFE_FRAMES_THREE   3'd3
`define DSFE_FRAMES_FOUR    3'd4

`endif

/* tb/dsfe_liu_model.sv */
// line unit and formatter stand-in: free-running line clocks, frame marker, transmit bits
// assumes a short frame so runs stay brief
`timescale 1ns/100ps
module dsfe_liu_model #(
  parameter int FRAME_BITS = 12             // bits per frame
) (
  output logic tx_line_clk,                 // transmit line clock
  output logic rx_line_clk,                 // receive line clock
  output logic tx_frame_start,              // first bit of frame
  output logic tx_data,                     // transmit bit
  output logic tx_subst_due,                // substitution point
  output logic liu_los,                     // loss of signal
  input  logic line_dead                    // bench asks for no signal
);
  int bit_n = 0;
  initial tx_line_clk = 1'b0;
  always #160 tx_line_clk = ~tx_line_clk;
  // rx runs at the same rate but shifted, so the two never share edges
  initial begin
    rx_line_clk = 1'b0;
    #37;
    forever #160 rx_line_clk = ~rx_line_clk;
  end
  // bits change on the falling edge, clear of the sampling edge
  always @(negedge tx_line_clk) bit_n <= (bit_n + 1) % FRAME_BITS;
  assign tx_frame_start = (bit_n == 0);
  assign tx_data = (bit_n % 4 != 3);
  assign tx_subst_due = (bit_n == 7);
  assign liu_los = line_dead;
endmodule // dsfe_liu_model

/* tb/dsfe_top_checker.sv */
// port-level assertions for the error insert block
// assumes clk_en stays high, so every core edge counts
`timescale 1ns/100ps
module dsfe_top_checker (
  input wire logic        core_clk,         // core clock
  input wire logic        arst_n,           // async reset, active low
  input wire logic [7:0]  avs_address,      // byte address
  input wire logic        avs_read,         // read request
  input wire logic        avs_write,        // write request
  input wire logic [31:0] avs_readdata,     // read data
  input wire logic        avs_waitrequest,  // stall
  input wire logic        p_invert,         // P error frame
  input wire logic        cp_invert,        // CP error frame
  input wire logic        fbit_error,       // F error frame
  input wire logic        mbit_error,       // M error frame
  input wire logic        fas_one_bit,      // word one bit off
  input wire logic        fas_all_bits,     // word inverted
  input wire logic        bpv_now,          // violation pulse
  input wire logic        rx_resync         // resync pulse
);
  // ==========
  // cycles since the last accepted write to control two, saturating
  logic [2:0] since;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      since <= 3'h7;
    end else if (avs_write && !avs_waitrequest && avs_address == 8'h44) begin
      since <= 3'h0;
    end else if (since != 3'h7) begin
      since <= since + 3'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence quiet_s;
    !rx_resync [*4];
  endsequence
  wait_answer_a: assert property (req_s |=> !avs_waitrequest) else $error("request not answered");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  rdata_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper data set");
  resync_cause_a: assert property (rx_resync |-> since <= 3'h3) else $error("resync without write");
  resync_pulse_a: assert property (rx_resync |=> quiet_s) else $error("resync repeated");
  bpv_pulse_a: assert property (bpv_now |=> !bpv_now) else $error("violation pulse long");
  p_frame_a: assert property ($rose(p_invert) |-> p_invert [*8]) else $error("P error short");
  cp_frame_a: assert property ($rose(cp_invert) |-> cp_invert [*6]) else $error("CP error short");
  fas_kind_a: assert property (!(fas_one_bit && fas_all_bits)) else $error("two word kinds");
  line_kind_a: assert property (!((fbit_error || mbit_error) && (fas_one_bit || fas_all_bits)))
    else $error("both line kinds");
endmodule // dsfe_top_checker

bind dsfe_top dsfe_top_checker u_chk (.core_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .p_invert, .cp_invert, .fbit_error, .mbit_error, .fas_one_bit, .fas_all_bits, .bpv_now,
  .rx_resync);

/* tb/tb_dsfe_top.sv */
// self-checking bench: registers, insertion kinds, resync, far-end code, live status
// assumes the line model supplies clocks, frame markers and transmit bits
`timescale 1ns/100ps
module tb_dsfe_top;
  localparam int FB = 12;        // bits per frame
  localparam int FL = FB * 8;    // core cycles per frame
  logic        core_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00, rd, r;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'h1;
  logic        manual_insert_strobe = 1'b0, rx_fm_error = 1'b0, rx_cp_error = 1'b0, rx_los = 1'b0;
  logic        rx_oof = 1'b0, rx_ais = 1'b0, rx_rai = 1'b0, idle_signal_detected = 1'b0, rx_sef = 1'b0;
  logic        line_dead = 1'b0;
  logic        avs_waitrequest, tx_line_clk, tx_frame_start, tx_data, tx_subst_due, rx_line_clk, liu_los;
  logic        febe_c_zero, p_invert, cp_invert, fbit_error, mbit_error, fas_one_bit, fas_all_bits;
  logic        bpv_now, exz_suppress, rx_resync;
  logic [9:0]  o, po = 10'h0;
  logic [7:0]  mds[4] = '{8'h03, 8'h01, 8'h00, 8'h07};
  int          hi[10], rs[10], failures = 0, comparisons = 0;
  always #20 core_clk = ~core_clk;
  dsfe_liu_model #(.FRAME_BITS(FB)) liu (.tx_line_clk, .rx_line_clk, .tx_frame_start, .tx_data,
    .tx_subst_due, .liu_los, .line_dead);
  dsfe_top DUT (.core_clk, .arst_n, .clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .tx_line_clk, .tx_frame_start, .tx_data, .tx_subst_due,
    .manual_insert_strobe, .rx_line_clk, .rx_fm_error, .rx_cp_error, .rx_los, .liu_los, .rx_oof, .rx_ais,
    .rx_rai, .idle_signal_detected, .rx_sef, .febe_c_zero, .p_invert, .cp_invert, .fbit_error, .mbit_error,
    .fas_one_bit, .fas_all_bits, .bpv_now, .exz_suppress, .rx_resync);
  // ==========
  // output monitor: cycles high and rising edges per output
  assign o = {rx_resync, exz_suppress, bpv_now, fas_all_bits, fas_one_bit, mbit_error, fbit_error,
              cp_invert, p_invert, febe_c_zero};
  // falling edge: clear of the rising edge at which clr() and the checks run
  always @(negedge core_clk) begin
    for (int i = 0; i < 10; i++) begin
      if (o[i] === 1'b1) hi[i]++;
      if (o[i] === 1'b1 && po[i] !== 1'b1) rs[i]++;
    end
    po <= o;
  end
  task automatic clr();
    foreach (hi[i]) begin
      hi[i] = 0;
      rs[i] = 0;
    end
  endtask
  // one bus access; the answer edge is the only edge that counts
  task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) failures++;
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_cnt(input string nm, input int e, input int g);
    comparisons++;
    if (g != e) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // mode, then a clean zero-to-one edge of the insert bits
  task automatic run(input logic [7:0] md, input logic [7:0] ei, input int n);
    bus(1, 8'hc0, md);
    bus(1, 8'h48, ei & 8'h80);
    clr();
    bus(1, 8'h48, ei);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic stb();
    manual_insert_strobe <= 1'b1;
    repeat (4) @(posedge core_clk);
    manual_insert_strobe <= 1'b0;
    repeat (250) @(posedge core_clk);
  endtask
  // framing output k (F, M, one-bit word, inverted word) in core cycles
  function automatic int fr_exp(bit e3, int t, int k);
    int n;
    n = (t == 2) ? 4 : (t == 3) ? (e3 ? 4 : 3) : 1;
    if (k != (e3 ? 2 : 0) + t % 2) n = 0;
    return n * FL;
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    end_of_test();
  end
  initial begin
    void'($urandom(57));
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    bus(0, 8'h48, 8'h00);
    chk_reg("insert control reset", 8'h00, rd);
    repeat (4) begin
      r = $urandom & 8'h7f;
      bus(1, 8'h44, r);
      bus(0, 8'h44, 8'h00);
      chk_reg("control two", r & 8'hbf, rd);
    end
    bus(1, 8'h44, ~r, 4'he);
    bus(0, 8'h44, 8'h00);
    chk_reg("lane zero off", r & 8'hbf, rd);
    bus(1, 8'h08, 8'hff);
    bus(0, 8'h08, 8'h00);
    chk_reg("unmapped", 8'h00, rd);
    bus(1, 8'h44, 8'h00);
    repeat (4) begin
      r = $urandom;
      {rx_sef, idle_signal_detected, rx_rai, rx_ais, rx_oof, rx_los} <= r[5:0];
      repeat (6) @(posedge core_clk);
      bus(0, 8'h60, 8'h00);
      chk_reg("status", {2'b00, r[5:0]}, rd);
    end
    {rx_sef, idle_signal_detected, rx_rai, rx_ais, rx_oof, rx_los} <= 6'h00;
    // binary line mode: loss of signal must come from the line unit, not the framer
    bus(1, 8'hc0, 8'h04);
    for (int b = 0; b < 2; b++) begin
      {line_dead, rx_los} <= b ? 2'b01 : 2'b10;
      repeat (6) @(posedge core_clk);
      bus(0, 8'h60, 8'h00);
      chk_reg("binary los", {7'h00, !b[0]}, rd);
    end
    {line_dead, rx_los} <= 2'b00;
    for (int e = 0; e < 2; e++) for (int t = 0; t < 4; t++) begin
      run(e ? 8'h00 : 8'h01, {1'b0, t[1:0], 5'h10}, 700);
      for (int k = 0; k < 4; k++) chk_cnt("framing", fr_exp(e, t, k), hi[3 + k]);
    end
    foreach (mds[i]) begin
      run(mds[i], 8'h0f, 300);
      chk_cnt("p error", mds[i][0] ? FL : 0, hi[1]);
      chk_cnt("cp error", mds[i][1:0] == 2'b11 ? FL : 0, hi[2]);
      chk_cnt("violation", mds[i][2] ? 0 : 1, rs[7]);
      chk_cnt("excess zero", mds[i][2] ? 0 : 1, rs[8]);
    end
    run(8'h01, 8'h84, 20);
    stb();
    stb();
    chk_cnt("manual", 2 * FL, hi[1]);
    run(8'h01, 8'h80, 20);
    stb();
    chk_cnt("manual none", 0, hi[1]);
    clr();
    bus(1, 8'h44, 8'h80);
    bus(1, 8'h44, 8'h80);
    repeat (20) @(posedge core_clk);
    chk_cnt("resync", 1, rs[9]);
    bus(1, 8'hc0, 8'h03);
    for (int f = 0; f < 2; f++) begin
      bus(1, 8'h44, f ? 8'h30 : 8'h10);
      repeat (200) @(posedge core_clk);
      clr();
      repeat (200) @(posedge core_clk);
      chk_cnt("forced code", f ? 200 : 0, hi[0]);
    end
    bus(1, 8'h44, 8'h00);
    for (int c = 0; c < 3; c++) begin
      clr();
      {rx_oof, rx_cp_error, rx_fm_error} <= 3'b001 << c;
      repeat (40) @(posedge core_clk);
      {rx_oof, rx_cp_error, rx_fm_error} <= 3'b000;
      repeat (300) @(posedge core_clk);
      chk_cnt("auto code", 1, int'(hi[0] > 0));
    end
    bus(1, 8'hc0, 8'h00);
    rx_oof <= 1'b1;
    repeat (100) @(posedge core_clk);
    clr();
    repeat (200) @(posedge core_clk);
    chk_cnt("code in e3", 0, hi[0]);
    end_of_test();
  end
endmodule // tb_dsfe_top
